// ### hw/backup_ctrl_pkg.sv
`default_nettype none
package backup_ctrl_pkg;
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 25;
    // Qualification and watchdog times, in their own units
    localparam int unsigned SAG_QUAL_NS     = 9_000;
    localparam int unsigned CELL_QUAL_NS    = 20_000;
    localparam int unsigned HARD_HOLD_MS    = 2_000;
    localparam int unsigned CHARGE_MAX_NS   = 14_000;
    localparam int unsigned DISCH_MAX_NS    = 10_000;
    // Least times round up, longest times round down
    localparam int unsigned SAG_QUAL_CYC    = (SAG_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CELL_QUAL_CYC   = (CELL_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HARD_HOLD_CYC   = HARD_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned CHARGE_MAX_CYC  = CHARGE_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned DISCH_MAX_CYC   = DISCH_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned QUAL_W          = 32;
    localparam int unsigned SW_CNT_W        = 10;
    // Gas gauge
    localparam int unsigned PRESCALE_W      = 23;
    localparam int unsigned GAUGE_W         = 9;
    localparam int unsigned HIGH_CUR_STEP   = 4;
    localparam logic [8:0]  GAUGE_PRESET    = 9'h080;
    localparam logic [8:0]  GAUGE_FULL      = 9'h1FF;
    localparam logic [8:0]  GAUGE_ZERO      = 9'h000;
    localparam int unsigned RECHARGE_DIV    = 1000;
    typedef enum logic [4:0] {
        ST_NORMAL   = 5'b00001,
        ST_BACKUP   = 5'b00010,
        ST_FAST     = 5'b00100,
        ST_TRICKLE  = 5'b01000,
        ST_LOCKOUT  = 5'b10000
    } ctrl_state_type;
endpackage
`default_nettype wire

// ### hw/backup_fault_gas_gauge_ctrl.sv
`default_nettype none
module backup_fault_gas_gauge_ctrl
    import backup_ctrl_pkg::*;
#(
    parameter int unsigned HARD_HOLD_CYCLES = HARD_HOLD_CYC,
    parameter int unsigned RECHARGE_DIVIDE  = RECHARGE_DIV
) (
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    input  wire logic supply_sag_i,
    input  wire logic supply_alive_i,
    input  wire logic feedback_low_i,
    input  wire logic main_restored_i,
    input  wire logic cell_below_0v9_i,
    input  wire logic cell_below_1v_i,
    input  wire logic pin_below_0v25_i,
    input  wire logic over_temp_i,
    input  wire logic cell_swapped_i,
    input  wire logic lockout_clear_i,
    input  wire logic boost_pulse_i,
    input  wire logic high_current_i,
    input  wire logic charge_phase_i,
    input  wire logic discharge_phase_i,
    input  wire logic cycle_done_i,
    output logic      reset_o,
    output logic      backup_o,
    output logic      boost_en_o,
    output logic      low_side_off_o,
    output logic      high_side_off_o,
    output logic      fast_charge_o,
    output logic      trickle_o,
    output logic      low_cell_warning_o,
    output logic      hard_reset_o,
    output logic      lockout_o,
    output logic [8:0] gauge_o
);
    import backup_ctrl_pkg::*;

    // A zero hold count would leave the hard-reset filter always tripped; a zero divide acts as one
    if (HARD_HOLD_CYCLES < 1 || RECHARGE_DIVIDE < 1) begin : g_bad_count
        $error("count parameters must be at least one");
    end

    ctrl_state_type state_reg, state_next;
    logic [QUAL_W-1:0]     sag_cnt_reg, sag_cnt_next;
    logic [QUAL_W-1:0]     cell_cnt_reg, cell_cnt_next;
    logic [QUAL_W-1:0]     hard_cnt_reg, hard_cnt_next;
    logic [QUAL_W-1:0]     osc_cnt_reg, osc_cnt_next;
    logic [SW_CNT_W-1:0]   chg_cnt_reg, chg_cnt_next;
    logic [SW_CNT_W-1:0]   dis_cnt_reg, dis_cnt_next;
    logic [PRESCALE_W-1:0] pre_reg, pre_next;
    logic [GAUGE_W-1:0]    gauge_reg, gauge_next;
    logic                  boost_reg, boost_next;
    logic                  abnormal_reg, abnormal_next;
    logic                  sag_trip, cell_trip, hard_trip, fault;
    logic [PRESCALE_W:0]   pre_sum;

    always_comb begin
        sag_cnt_next  = '0;
        cell_cnt_next = '0;
        hard_cnt_next = '0;
        chg_cnt_next  = '0;
        dis_cnt_next  = '0;
        // Filters restart whenever their condition falls away
        if (supply_sag_i && sag_cnt_reg < QUAL_W'(SAG_QUAL_CYC)) begin
            sag_cnt_next = sag_cnt_reg + 1'b1;
        end else if (supply_sag_i) begin
            sag_cnt_next = sag_cnt_reg;
        end
        // Window 0.25..0.9 V only, and only during backup
        if (state_reg == ST_BACKUP && cell_below_0v9_i && !pin_below_0v25_i) begin
            cell_cnt_next = (cell_cnt_reg < QUAL_W'(CELL_QUAL_CYC)) ?
                            cell_cnt_reg + 1'b1 : cell_cnt_reg;
        end
        if (pin_below_0v25_i) begin
            hard_cnt_next = (hard_cnt_reg < QUAL_W'(HARD_HOLD_CYCLES)) ?
                            hard_cnt_reg + 1'b1 : hard_cnt_reg;
        end
        if (boost_reg && charge_phase_i && chg_cnt_reg < SW_CNT_W'(CHARGE_MAX_CYC)) begin
            chg_cnt_next = chg_cnt_reg + 1'b1;
        end else if (boost_reg && charge_phase_i) begin
            chg_cnt_next = chg_cnt_reg;
        end
        if (boost_reg && discharge_phase_i && dis_cnt_reg < SW_CNT_W'(DISCH_MAX_CYC)) begin
            dis_cnt_next = dis_cnt_reg + 1'b1;
        end else if (boost_reg && discharge_phase_i) begin
            dis_cnt_next = dis_cnt_reg;
        end
    end

    assign sag_trip  = sag_cnt_reg >= QUAL_W'(SAG_QUAL_CYC);
    assign cell_trip = cell_cnt_reg >= QUAL_W'(CELL_QUAL_CYC);
    assign hard_trip = hard_cnt_reg >= QUAL_W'(HARD_HOLD_CYCLES);
    assign fault     = sag_trip || cell_trip || hard_trip || over_temp_i;
    assign pre_sum   = {1'b0, pre_reg} + (high_current_i ?
                       (PRESCALE_W+1)'(HIGH_CUR_STEP) : (PRESCALE_W+1)'(1));

    always_comb begin
        state_next    = state_reg;
        pre_next      = pre_reg;
        gauge_next    = gauge_reg;
        boost_next    = boost_reg;
        abnormal_next = abnormal_reg;
        osc_cnt_next  = '0;
        unique case (state_reg)
            ST_NORMAL: begin
                if (feedback_low_i) begin
                    state_next = ST_BACKUP;
                    boost_next = 1'b1;
                end
            end
            ST_BACKUP: begin
                if (boost_pulse_i && gauge_reg != GAUGE_FULL) begin
                    pre_next = pre_sum[PRESCALE_W-1:0];
                    if (pre_sum[PRESCALE_W]) begin
                        gauge_next = gauge_reg + 1'b1;
                    end
                end
                if (cell_swapped_i) begin
                    abnormal_next = 1'b1;
                end
                if (main_restored_i) begin
                    state_next = ST_FAST;
                    pre_next   = '0;
                    // Saturate, then add one step on exit
                    gauge_next = abnormal_reg || cell_swapped_i ? GAUGE_PRESET :
                                 (gauge_next == GAUGE_FULL ? GAUGE_FULL : gauge_next + 1'b1);
                    abnormal_next = 1'b0;
                end
            end
            ST_FAST: begin
                if (osc_cnt_reg + 1'b1 >= QUAL_W'(RECHARGE_DIVIDE)) begin
                    if (gauge_reg != GAUGE_ZERO) begin
                        gauge_next = gauge_reg - 1'b1;
                    end
                end else begin
                    osc_cnt_next = osc_cnt_reg + 1'b1;
                end
                if (gauge_reg == GAUGE_ZERO) begin
                    state_next = ST_TRICKLE;
                end else if (feedback_low_i) begin
                    state_next = ST_BACKUP;
                    boost_next = 1'b1;
                end
            end
            ST_TRICKLE: begin
                if (feedback_low_i) begin
                    state_next = ST_BACKUP;
                    boost_next = 1'b1;
                end
            end
            ST_LOCKOUT: begin
                if (lockout_clear_i && !fault) begin
                    state_next = ST_FAST;
                    gauge_next = GAUGE_PRESET;
                    pre_next   = '0;
                end
            end
            default: begin
                state_next = ST_LOCKOUT;
            end
        endcase
        // Boost halts only once the running cycle finishes, unless a fault locks out
        if (state_next != ST_BACKUP && boost_reg && cycle_done_i) begin
            boost_next = 1'b0;
        end
        // Lockout overrides the next state and the boost enable
        if (fault && state_reg != ST_LOCKOUT) begin
            state_next = ST_LOCKOUT;
            boost_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            state_reg    <= ST_NORMAL;
            sag_cnt_reg  <= '0;
            cell_cnt_reg <= '0;
            hard_cnt_reg <= '0;
            osc_cnt_reg  <= '0;
            chg_cnt_reg  <= '0;
            dis_cnt_reg  <= '0;
            pre_reg      <= '0;
            gauge_reg    <= GAUGE_PRESET;
            boost_reg    <= 1'b0;
            abnormal_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            sag_cnt_reg  <= sag_cnt_next;
            cell_cnt_reg <= cell_cnt_next;
            hard_cnt_reg <= hard_cnt_next;
            osc_cnt_reg  <= osc_cnt_next;
            chg_cnt_reg  <= chg_cnt_next;
            dis_cnt_reg  <= dis_cnt_next;
            pre_reg      <= pre_next;
            gauge_reg    <= gauge_next;
            boost_reg    <= boost_next;
            abnormal_reg <= abnormal_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            reset_o            <= 1'b1;
            backup_o           <= 1'b0;
            boost_en_o         <= 1'b0;
            low_side_off_o     <= 1'b0;
            high_side_off_o    <= 1'b0;
            fast_charge_o      <= 1'b0;
            trickle_o          <= 1'b0;
            low_cell_warning_o <= 1'b0;
            hard_reset_o       <= 1'b0;
            lockout_o          <= 1'b0;
            gauge_o            <= GAUGE_PRESET;
        end else begin
            // Held while supervisor alive in lockout
            reset_o            <= state_next == ST_LOCKOUT && supply_alive_i;
            backup_o           <= state_next == ST_BACKUP;
            boost_en_o         <= boost_next;
            low_side_off_o     <= chg_cnt_next >= SW_CNT_W'(CHARGE_MAX_CYC);
            high_side_off_o    <= dis_cnt_next >= SW_CNT_W'(DISCH_MAX_CYC);
            fast_charge_o      <= state_next == ST_FAST;
            trickle_o          <= state_next == ST_TRICKLE;
            low_cell_warning_o <= cell_below_1v_i && state_next != ST_TRICKLE;
            hard_reset_o       <= hard_trip;
            lockout_o          <= state_next == ST_LOCKOUT;
            gauge_o            <= gauge_next;
        end
    end

    a_sag_lockout: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        sag_trip |=> state_reg == ST_LOCKOUT)
        else $error("sag did not lock out");
    a_cell_lockout: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        cell_trip |=> lockout_o)
        else $error("low cell did not lock out");
    a_hard_lockout: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        hard_trip |=> lockout_o && hard_reset_o)
        else $error("hard reset not issued");
    a_warn_trickle: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        trickle_o |-> !low_cell_warning_o)
        else $error("warning during trickle");
    a_temp_lockout: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        over_temp_i |=> state_reg == ST_LOCKOUT)
        else $error("thermal did not lock out");
    a_gauge_nowrap: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_reg == ST_BACKUP && $past(state_reg) == ST_BACKUP
        |-> !($past(gauge_reg) == GAUGE_FULL && gauge_reg == GAUGE_ZERO))
        else $error("gauge wrapped");
    a_trickle_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_reg == ST_FAST && gauge_reg == GAUGE_ZERO && !fault
        |=> state_reg == ST_TRICKLE)
        else $error("no trickle at zero");
    a_backup_entry: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_reg == ST_NORMAL && feedback_low_i && !fault |=> backup_o && boost_en_o)
        else $error("backup not entered");
    a_onehot_state: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $onehot(state_reg))
        else $error("state not one-hot");
    a_sag_restart: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !supply_sag_i |=> sag_cnt_reg == '0)
        else $error("sag filter did not restart");
    a_cell_pushbutton: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        pin_below_0v25_i |=> cell_cnt_reg == '0)
        else $error("pushbutton counted as low cell");
    a_low_watchdog: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        boost_reg && charge_phase_i && chg_cnt_reg == SW_CNT_W'(CHARGE_MAX_CYC - 1)
        |=> low_side_off_o)
        else $error("charge watchdog did not fire");
    a_prescale_unit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_reg == ST_BACKUP && boost_pulse_i && !high_current_i
        && gauge_reg != GAUGE_FULL && !main_restored_i
        |=> pre_reg == $past(pre_reg) + 1'b1)
        else $error("low current pulse not counted");
    a_prescale_step: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_reg == ST_BACKUP && boost_pulse_i && high_current_i
        && gauge_reg != GAUGE_FULL && !main_restored_i
        |=> pre_reg == $past(pre_reg) + PRESCALE_W'(HIGH_CUR_STEP))
        else $error("high current pulse not weighted");
    a_exit_step: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_reg == ST_BACKUP && main_restored_i && !boost_pulse_i && !abnormal_reg
        && !cell_swapped_i && gauge_reg != GAUGE_FULL |=> gauge_reg == $past(gauge_reg) + 1'b1)
        else $error("no step added on backup exit");
    a_swap_preset: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_reg == ST_BACKUP && main_restored_i && (abnormal_reg || cell_swapped_i)
        |=> gauge_reg == GAUGE_PRESET)
        else $error("gauge not preset after swap");
    a_lockout_exit: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        state_reg == ST_LOCKOUT && lockout_clear_i && !fault
        |=> fast_charge_o && gauge_o == GAUGE_PRESET)
        else $error("lockout exit did not recharge");
    a_boost_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        boost_reg && !cycle_done_i && !fault |=> boost_en_o)
        else $error("boost stopped mid cycle");
endmodule
`default_nettype wire

// ### test/boost_stage_model.sv
`default_nettype none
module boost_stage_model (
    input  wire logic mclk_i,
    input  wire logic boost_en_i,
    input  wire logic slow_i,
    output logic      charge_o,
    output logic      disch_o,
    output logic      pulse_o,
    output logic      hi_cur_o,
    output logic      done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    int run = 0;
    initial {charge_o, disch_o, pulse_o, hi_cur_o, done_o} = 5'h00;
    // Slow mode stands for an oversized inductor or an overload
    always @(posedge mclk_i) begin
        pulse_o <= 1'b0;
        done_o <= 1'b0;
        cnt <= cnt + 1;
        if (!boost_en_i) begin
            run <= 0;
        end
        if (charge_o && cnt >= (slow_i ? 600 : 20)) begin
            charge_o <= 1'b0;
            disch_o <= 1'b1;
            cnt <= 0;
        end else if (disch_o && cnt >= (slow_i ? 450 : 10)) begin
            // A started cycle always runs to its end
            disch_o <= 1'b0;
            pulse_o <= 1'b1;
            done_o <= 1'b1;
            hi_cur_o <= (run >= 2);
            run <= run + 1;
        end else if (!charge_o && !disch_o && !done_o && boost_en_i) begin
            charge_o <= 1'b1;
            cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// ### test/test_backup_fault_gas_gauge_ctrl.sv
`default_nettype none
module test_backup_fault_gas_gauge_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import backup_ctrl_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic supply_sag_i = 1'b0, supply_alive_i = 1'b1, feedback_low_i = 1'b0;
    logic main_restored_i = 1'b0, cell_below_0v9_i = 1'b0, cell_below_1v_i = 1'b0;
    logic pin_below_0v25_i = 1'b0, over_temp_i = 1'b0, lockout_clear_i = 1'b0, slow = 1'b0;
    logic cell_swapped_i = 1'b0;
    logic boost_pulse_i, high_current_i, charge_phase_i, discharge_phase_i, cycle_done_i;
    logic reset_o, backup_o, boost_en_o, low_side_off_o, high_side_off_o, fast_charge_o;
    logic trickle_o, low_cell_warning_o, hard_reset_o, lockout_o;
    logic [8:0] gauge_o;
    int failures = 0, n_tests = 0, cyc = 0, k = 0;
    // Faults in order: sag, over-temperature, pin low, cell low
    typedef struct {logic [3:0] f; logic twice, lk, hd; int n;} row_type;
    row_type rows [6] = '{
        '{4'h8, 1, 0, 0, 350},  // Two short sags do not add up
        '{4'h8, 0, 1, 0, 370},  // Long sag locks out
        '{4'h4, 0, 1, 0, 3},    // Over-temperature locks out
        '{4'h2, 1, 0, 0, 45},   // Two short presses do not add up
        '{4'h2, 0, 1, 1, 60},   // Long press gives hard reset
        '{4'h1, 0, 0, 0, 850}}; // Low cell outside backup ignored

    backup_fault_gas_gauge_ctrl #(.HARD_HOLD_CYCLES(50), .RECHARGE_DIVIDE(4)) dut (
        .mclk_i, .rstn_i, .supply_sag_i, .supply_alive_i, .feedback_low_i,
        .main_restored_i, .cell_below_0v9_i, .cell_below_1v_i, .pin_below_0v25_i,
        .over_temp_i, .cell_swapped_i, .lockout_clear_i, .boost_pulse_i,
        .high_current_i, .charge_phase_i, .discharge_phase_i, .cycle_done_i, .reset_o,
        .backup_o, .boost_en_o, .low_side_off_o, .high_side_off_o, .fast_charge_o,
        .trickle_o, .low_cell_warning_o, .hard_reset_o, .lockout_o, .gauge_o);
    boost_stage_model partner (.mclk_i, .boost_en_i(boost_en_o), .slow_i(slow),
        .charge_o(charge_phase_i), .disch_o(discharge_phase_i), .pulse_o(boost_pulse_i),
        .hi_cur_o(high_current_i), .done_o(cycle_done_i));

    always #12.5 mclk_i = ~mclk_i;

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    // Leaves the cycles waited in k
    task automatic wait_for(ref logic s, input int lim);
        k = 0;
        while (s !== 1'b1 && k < lim) begin
            tick(1);
            k++;
        end
        check(k < lim, 9'h001);
    endtask

    task automatic set_faults(input logic [3:0] v);
        {supply_sag_i, over_temp_i, pin_below_0v25_i, cell_below_0v9_i} = v;
    endtask

    task automatic recover();
        // A trip filter still reads full for one edge after its input drops
        tick(1);
        lockout_clear_i = 1'b1;
        tick(1);
        lockout_clear_i = 1'b0;
        check(lockout_o, 1'b0);
        check(fast_charge_o, 1'b1);
        check(gauge_o, GAUGE_PRESET);
        wait_for(trickle_o, 600);
        check(fast_charge_o, 1'b0);
        check(gauge_o, 9'h000);
    endtask

    initial begin
        tick(20);
        check(reset_o, 1'b1);
        check(gauge_o, GAUGE_PRESET);
        rstn_i = 1'b1;
        tick(2);
        check(backup_o, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].twice) begin
                set_faults(rows[i].f);
                tick(rows[i].n);
                set_faults(4'h0);
                tick(1);
            end
            set_faults(rows[i].f);
            tick(rows[i].n);
            check(lockout_o, rows[i].lk);
            check(reset_o, rows[i].lk);
            check(hard_reset_o, rows[i].hd);
            set_faults(4'h0);
            if (rows[i].lk) begin
                recover();
            end
            $display("row %0d done", i);
        end
        cell_below_1v_i = 1'b1;
        feedback_low_i = 1'b1;
        tick(1);
        check(backup_o, 1'b1);
        check(boost_en_o, 1'b1);
        wait_for(charge_phase_i, 5);
        check(low_cell_warning_o, 1'b1);
        main_restored_i = 1'b1;
        feedback_low_i = 1'b0;
        tick(1);
        check(fast_charge_o, 1'b1);
        check(gauge_o, 9'h001);
        check(boost_en_o, 1'b1);
        wait_for(cycle_done_i, 40);
        tick(1);
        check(boost_en_o, 1'b0);
        wait_for(trickle_o, 20);
        check(low_cell_warning_o, 1'b0);
        $display("test walk done");
        main_restored_i = 1'b0;
        feedback_low_i = 1'b1;
        tick(2);
        cell_swapped_i = 1'b1;
        tick(1);
        {cell_swapped_i, feedback_low_i, main_restored_i} = 3'h1;
        tick(1);
        check(fast_charge_o, 1'b1);
        check(gauge_o, GAUGE_PRESET);
        wait_for(trickle_o, 600);
        check(gauge_o, 9'h000);
        $display("test cell swap done");
        slow = 1'b1;
        cell_below_1v_i = 1'b0;
        main_restored_i = 1'b0;
        feedback_low_i = 1'b1;
        wait_for(charge_phase_i, 10);
        wait_for(low_side_off_o, 700);
        check(k >= 555 && k <= 565, 9'h001);
        wait_for(discharge_phase_i, 100);
        wait_for(high_side_off_o, 500);
        check(k >= 395 && k <= 405, 9'h001);
        $display("test watchdog done");
        cell_below_0v9_i = 1'b1;
        repeat (16) begin
            pin_below_0v25_i = 1'b1;
            tick(30);
            pin_below_0v25_i = 1'b0;
            tick(30);
        end
        check(lockout_o, 1'b0);
        tick(790);
        check(lockout_o, 1'b1);
        check(backup_o, 1'b0);
        supply_alive_i = 1'b0;
        tick(1);
        check(reset_o, 1'b0);
        supply_alive_i = 1'b1;
        tick(1);
        check(reset_o, 1'b1);
        {feedback_low_i, cell_below_0v9_i, slow} = 3'h0;
        recover();
        $display("test low cell done");
        give_verdict();
    end
endmodule
`default_nettype wire
